//--- fpph_defs.svh
// constants for the serial flash power, protection and pause logic
// assumes a 10 MHz ref_clk; included by both link ends
`ifndef FPPH_DEFS_SVH
`define FPPH_DEFS_SVH

`define FPPH_REF_NS 100
`define FPPH_PUW_NS 10000
`define FPPH_PUW_CYC ((`FPPH_PUW_NS + `FPPH_REF_NS - 1) / `FPPH_REF_NS)
`define FPPH_HALF_NS 400
`define FPPH_HALF_CYC (`FPPH_HALF_NS / `FPPH_REF_NS)

`define FPPH_OP_SET_LATCH 8'h06
`define FPPH_OP_CLR_LATCH 8'h04
`define FPPH_OP_READ_STAT 8'h05
`define FPPH_OP_STAT_WRITE 8'h01
`define FPPH_OP_PAGE_PROG 8'h02
`define FPPH_OP_BLOCK_WIPE 8'hd8
`define FPPH_OP_FULL_WIPE 8'hc7
`define FPPH_OP_POWER_DOWN 8'hb9
`define FPPH_OP_WAKE 8'hab

`define FPPH_ST_LOCK 7
`define FPPH_ST_LVL_HI 4
`define FPPH_ST_LVL_LO 2
`define FPPH_ST_LATCH 1
`define FPPH_ST_BUSY 0

`define FPPH_BYTES_SW 3'h2
`define FPPH_BYTES_PP 3'h5
`define FPPH_BYTES_BW 3'h4

`endif

//--- fpph_pkg.sv
// types shared by both ends of the serial flash link
// no assumptions beyond a SystemVerilog compiler
package fpph_pkg;
  typedef enum logic [1:0] {
    FPPH_STANDBY = 2'b00,
    FPPH_ACTIVE = 2'b01,
    FPPH_DEEP = 2'b10
  } fpph_mode_t;

  typedef enum logic [1:0] {
    FPPH_K_STATUS = 2'b00,
    FPPH_K_PROGRAM = 2'b01,
    FPPH_K_BLOCK = 2'b10,
    FPPH_K_FULL = 2'b11
  } fpph_kind_t;

  typedef enum logic [2:0] {
    FPPH_H_IDLE = 3'b000,
    FPPH_H_SEL = 3'b001,
    FPPH_H_LOW = 3'b010,
    FPPH_H_HIGH = 3'b011,
    FPPH_H_GAP = 3'b100
  } fpph_hstate_t;
endpackage

//--- fpph_link_if.sv
// serial link between the host end and the flash end
// serial_out line has a pull-up: reads one when nobody drives it
`timescale 1ns/10ps
`default_nettype none
interface fpph_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic pause_n;
  logic protect_n;
  logic miso_o;
  logic miso_oe;
  logic miso;

  assign miso = miso_oe ? miso_o : 1'b1;

  modport dev (
    input cs_n,
    input sck,
    input mosi,
    input pause_n,
    input protect_n,
    output miso_o,
    output miso_oe
  );

  modport host (
    output cs_n,
    output sck,
    output mosi,
    output pause_n,
    output protect_n,
    input miso
  );
endinterface
`default_nettype wire

//--- fpph_flash_end.sv
// flash end: serial front on the link clock, power and protection on ref_clk
// assumes the array model answers core_start with one core_done pulse
`include "fpph_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module fpph_flash_end (
  input wire logic ref_clk,
  input wire logic rst,
  fpph_link_if.dev link,
  input wire logic core_done,
  output logic core_start,
  output fpph_pkg::fpph_kind_t core_kind,
  output logic [3:0] core_sector,
  output logic [2:0] protect_level,
  output logic status_lock,
  output logic write_latch,
  output logic busy,
  output fpph_pkg::fpph_mode_t power_mode
);
  // protected sector test
  function automatic logic sector_locked(input logic [2:0] lvl, input logic [3:0] sec);
    logic r;
    r = 1'b0;
    case (lvl)
      3'h0: r = 1'b0;
      3'h1: r = (sec == 4'hf);
      3'h2: r = (sec >= 4'he);
      3'h3: r = (sec >= 4'hc);
      3'h4: r = (sec >= 4'h8);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  // link clock domain
  logic started;
  logic frame_tgl;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] sh;
  logic [7:0] op_byte;
  logic [7:0] arg_byte;
  logic [7:0] st_s1;
  logic [7:0] st_s2;
  logic [7:0] st_s3;
  logic [7:0] st_lnk;
  logic [7:0] next_byte;
  logic oe_q;

  assign next_byte = {sh[6:0], link.mosi};

  // cleared whenever deselected, also mid-pause
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
      started <= 1'b0;
    else if (link.pause_n)
      started <= 1'b1;
  end

  // bits shift only on unpaused rising edges
  always_ff @(posedge link.sck or posedge rst)
  begin
    if (rst)
    begin
      frame_tgl <= 1'b0;
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      sh <= 8'h00;
      op_byte <= 8'h00;
      arg_byte <= 8'h00;
    end
    else if (!link.cs_n && link.pause_n)
    begin
      sh <= next_byte;
      if (!started)
      begin
        frame_tgl <= ~frame_tgl;
        bit_cnt <= 3'h1;
        byte_cnt <= 3'h0;
      end
      else
      begin
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7)
        begin
          if (byte_cnt != 3'h7)
            byte_cnt <= byte_cnt + 3'h1;
          if (byte_cnt == 3'h0)
            op_byte <= next_byte;
          if (byte_cnt == 3'h1)
            arg_byte <= next_byte;
        end
      end
    end
  end

  // status word into the link domain
  always_ff @(posedge link.sck or posedge rst)
  begin
    if (rst)
    begin
      st_s1 <= 8'h00;
      st_s2 <= 8'h00;
      st_s3 <= 8'h00;
      st_lnk <= 8'h00;
    end
    else
    begin
      st_s1 <= {status_lock, 2'b00, protect_level, write_latch, busy};
      st_s2 <= st_s1;
      st_s3 <= st_s2;
      st_lnk <= (st_s2 & st_s3) | (st_lnk & (st_s2 | st_s3));
    end
  end

  // status readout on falling edges
  always_ff @(negedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      link.miso_o <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      oe_q <= link.pause_n && started && (byte_cnt != 3'h0)
        && (op_byte == `FPPH_OP_READ_STAT);
      link.miso_o <= st_lnk[~bit_cnt];
    end
  end

  // no sck fall comes during a pause, so release the line from pause_n itself
  assign link.miso_oe = oe_q && link.pause_n;

  // ref_clk domain: pins and frame toggle through three flops and a filter flop
  logic [2:0] in_s1;
  logic [2:0] in_s2;
  logic [2:0] in_s3;
  logic [2:0] in_f;
  logic cs_prev;
  logic tgl_seen;
  logic [7:0] puw_cnt;
  logic inhibit;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      in_s1 <= 3'b011;
      in_s2 <= 3'b011;
      in_s3 <= 3'b011;
      in_f <= 3'b011;
      cs_prev <= 1'b1;
    end
    else
    begin
      in_s1 <= {frame_tgl, link.protect_n, link.cs_n};
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      in_f <= (in_s2 & in_s3) | (in_f & (in_s2 | in_s3));
      cs_prev <= in_f[0];
    end
  end

  // power-up write inhibit timer
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      puw_cnt <= 8'h00;
    else if (inhibit)
      puw_cnt <= puw_cnt + 8'h01;
  end
  assign inhibit = (puw_cnt != 8'(`FPPH_PUW_CYC));

  // frame decode at deselect; link side is quiet then
  logic exec;
  logic ok8;
  logic live;
  logic wr_ok;
  logic hw_locked;
  logic acc_set;
  logic acc_clr;
  logic acc_sw;
  logic acc_pp;
  logic acc_bw;
  logic acc_fw;
  logic acc_pd;
  logic acc_wake;

  always_comb
  begin
    exec = in_f[0] && !cs_prev && (in_f[2] != tgl_seen);
    ok8 = (bit_cnt == 3'h0) && (byte_cnt != 3'h0);
    live = exec && (power_mode != fpph_pkg::FPPH_DEEP) && !busy;
    wr_ok = live && ok8 && write_latch && !inhibit;
    hw_locked = status_lock && !in_f[1];
    acc_set = live && ok8 && (op_byte == `FPPH_OP_SET_LATCH);
    acc_clr = live && ok8 && (op_byte == `FPPH_OP_CLR_LATCH);
    acc_sw = wr_ok && (op_byte == `FPPH_OP_STAT_WRITE) && (byte_cnt >= `FPPH_BYTES_SW)
      && !hw_locked;
    acc_pp = wr_ok && (op_byte == `FPPH_OP_PAGE_PROG) && (byte_cnt >= `FPPH_BYTES_PP)
      && !sector_locked(protect_level, arg_byte[3:0]);
    acc_bw = wr_ok && (op_byte == `FPPH_OP_BLOCK_WIPE) && (byte_cnt >= `FPPH_BYTES_BW)
      && !sector_locked(protect_level, arg_byte[3:0]);
    acc_fw = wr_ok && (op_byte == `FPPH_OP_FULL_WIPE) && (protect_level == 3'h0);
    acc_pd = live && ok8 && (op_byte == `FPPH_OP_POWER_DOWN);
    acc_wake = exec && (power_mode == fpph_pkg::FPPH_DEEP)
      && (op_byte == `FPPH_OP_WAKE);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tgl_seen <= 1'b0;
    else if (exec)
      tgl_seen <= in_f[2];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      write_latch <= 1'b0;
    else if (acc_set)
      write_latch <= 1'b1;
    else if (acc_clr || acc_sw || acc_pp || acc_bw || acc_fw)
      write_latch <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      protect_level <= 3'h0;
      status_lock <= 1'b0;
    end
    else if (acc_sw)
    begin
      protect_level <= arg_byte[`FPPH_ST_LVL_HI:`FPPH_ST_LVL_LO];
      status_lock <= arg_byte[`FPPH_ST_LOCK];
    end
  end

  // internal cycle hand-off; the pause pin never reaches here
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      core_start <= 1'b0;
      core_kind <= fpph_pkg::FPPH_K_STATUS;
      core_sector <= 4'h0;
      busy <= 1'b0;
    end
    else
    begin
      core_start <= acc_sw || acc_pp || acc_bw || acc_fw;
      core_sector <= arg_byte[3:0];
      if (acc_sw)
        core_kind <= fpph_pkg::FPPH_K_STATUS;
      else if (acc_pp)
        core_kind <= fpph_pkg::FPPH_K_PROGRAM;
      else if (acc_bw)
        core_kind <= fpph_pkg::FPPH_K_BLOCK;
      else if (acc_fw)
        core_kind <= fpph_pkg::FPPH_K_FULL;
      if (acc_sw || acc_pp || acc_bw || acc_fw)
        busy <= 1'b1;
      else if (core_done)
        busy <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      power_mode <= fpph_pkg::FPPH_STANDBY;
    else if (acc_pd)
      power_mode <= fpph_pkg::FPPH_DEEP;
    else if (power_mode == fpph_pkg::FPPH_DEEP)
    begin
      if (acc_wake)
        power_mode <= fpph_pkg::FPPH_ACTIVE;
    end
    else if (!in_f[0] || busy)
      power_mode <= fpph_pkg::FPPH_ACTIVE;
    else
      power_mode <= fpph_pkg::FPPH_STANDBY;
  end
endmodule
`default_nettype wire

//--- fpph_host_end.sv
// host end: makes the link clock from ref_clk and sends one command at a time
// assumes the flash end sits on the other side of the link interface
`include "fpph_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module fpph_host_end (
  input wire logic ref_clk,
  input wire logic rst,
  fpph_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [31:0] cmd_arg,
  input wire logic [2:0] cmd_nbytes,
  input wire logic cmd_auto_latch,
  input wire logic pause_req,
  input wire logic protect_drive_n,
  output logic cmd_ready,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  fpph_pkg::fpph_hstate_t state;
  logic [39:0] sh;
  logic [39:0] main_sh;
  logic [5:0] bits_left;
  logic [5:0] main_bits;
  logic pre;
  logic [2:0] tick;
  logic half_done;
  logic miso_s1;
  logic miso_s2;
  logic miso_s3;
  logic miso_f;

  assign half_done = (tick == 3'(`FPPH_HALF_CYC - 1));

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      miso_s1 <= 1'b1;
      miso_s2 <= 1'b1;
      miso_s3 <= 1'b1;
      miso_f <= 1'b1;
      link.protect_n <= 1'b1;
    end
    else
    begin
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
      miso_s3 <= miso_s2;
      if (miso_s2 == miso_s3)
        miso_f <= miso_s3;
      link.protect_n <= protect_drive_n;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= fpph_pkg::FPPH_H_IDLE;
      link.cs_n <= 1'b1;
      link.sck <= 1'b0;
      link.mosi <= 1'b0;
      link.pause_n <= 1'b1;
      sh <= 40'h0;
      main_sh <= 40'h0;
      bits_left <= 6'h0;
      main_bits <= 6'h0;
      pre <= 1'b0;
      tick <= 3'h0;
      cmd_ready <= 1'b1;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      tick <= half_done ? 3'h0 : tick + 3'h1;
      case (state)
        fpph_pkg::FPPH_H_IDLE:
        begin
          tick <= 3'h0;
          if (cmd_valid)
          begin
            cmd_ready <= 1'b0;
            main_sh <= {cmd_op, cmd_arg};
            main_bits <= {cmd_nbytes, 3'h0};
            pre <= cmd_auto_latch;
            sh <= cmd_auto_latch ? {`FPPH_OP_SET_LATCH, 32'h0} : {cmd_op, cmd_arg};
            bits_left <= cmd_auto_latch ? 6'h08 : {cmd_nbytes, 3'h0};
            link.cs_n <= 1'b0;
            state <= fpph_pkg::FPPH_H_SEL;
          end
        end
        fpph_pkg::FPPH_H_SEL:
          if (half_done)
          begin
            link.mosi <= sh[39];
            state <= fpph_pkg::FPPH_H_LOW;
          end
        fpph_pkg::FPPH_H_LOW:
        begin
          link.pause_n <= !pause_req;
          if (pause_req || !link.pause_n)
            tick <= 3'h0;
          else if (half_done)
          begin
            link.sck <= 1'b1;
            state <= fpph_pkg::FPPH_H_HIGH;
          end
        end
        fpph_pkg::FPPH_H_HIGH:
          if (half_done)
          begin
            link.sck <= 1'b0;
            rx_byte <= {rx_byte[6:0], miso_f};
            sh <= {sh[38:0], 1'b0};
            link.mosi <= sh[38];
            bits_left <= bits_left - 6'h01;
            if (bits_left == 6'h01)
            begin
              link.cs_n <= 1'b1;
              state <= fpph_pkg::FPPH_H_GAP;
            end
            else
              state <= fpph_pkg::FPPH_H_LOW;
          end
        fpph_pkg::FPPH_H_GAP:
          if (half_done)
          begin
            if (pre)
            begin
              pre <= 1'b0;
              sh <= main_sh;
              bits_left <= main_bits;
              link.cs_n <= 1'b0;
              state <= fpph_pkg::FPPH_H_SEL;
            end
            else
            begin
              cmd_ready <= 1'b1;
              rx_valid <= 1'b1;
              state <= fpph_pkg::FPPH_H_IDLE;
            end
          end
        default:
          state <= fpph_pkg::FPPH_H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- fpph_asserts.sv
// link checker: watches the wire between host end and flash end
// instantiated beside the link interface by the bench, one ref_clk domain
`timescale 1ns/10ps
`default_nettype none
module fpph_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic pause_n,
  input wire logic miso_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_pause_sel: assert property (!pause_n |-> !cs_n)
    else $error("pause while deselected");
  a_pause_start: assert property ($fell(pause_n) |-> !sck)
    else $error("pause began with clock high");
  a_pause_still: assert property (!pause_n && !$past(pause_n) |-> $stable(sck))
    else $error("clock moved during pause");
  a_pause_end: assert property ($rose(pause_n) |-> !sck)
    else $error("pause ended with clock high");
  a_keep_sel: assert property ($rose(cs_n) |-> pause_n && $past(pause_n))
    else $error("deselect during pause");
  a_release_first: assert property ($fell(cs_n) |-> pause_n)
    else $error("select while pause held");
  a_pause_hiz: assert property (!pause_n [*3] |-> !miso_oe)
    else $error("data out driven in pause");
  a_desel_hiz: assert property (cs_n [*3] |-> !miso_oe)
    else $error("data out driven while deselected");
  a_sck_shape: assert property ($rose(sck) |-> (sck && $stable(mosi)) [*4] ##1 !sck)
    else $error("clock high phase wrong");
endmodule
`default_nettype wire

//--- fpph_tb_top.sv
// bench: host end and flash end joined over the link interface
// the flash array is modelled here: core_done 300 cycles after core_start
`include "fpph_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module fpph_tb_top;
  logic ref_clk, rst, cmd_valid, cmd_auto_latch, pause_req, protect_drive_n, pr;
  logic cmd_ready, rx_valid, core_start, status_lock, write_latch, busy;
  logic core_done = 1'b0;
  logic [7:0] cmd_op, rx_byte, lfsr;
  logic [31:0] cmd_arg;
  logic [2:0] cmd_nbytes, protect_level, lvl;
  logic [3:0] core_sector, sec;
  fpph_pkg::fpph_kind_t core_kind;
  fpph_pkg::fpph_mode_t power_mode;
  int errors, checks_done, starts, exp_st, cyc, core_wait;
  fpph_link_if link ();
  fpph_host_end fpph_host_end_i (.ref_clk(ref_clk), .rst(rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_nbytes(cmd_nbytes),
    .cmd_auto_latch(cmd_auto_latch), .pause_req(pause_req), .protect_drive_n(protect_drive_n),
    .cmd_ready(cmd_ready), .rx_byte(rx_byte), .rx_valid(rx_valid));
  fpph_flash_end fpph_flash_end_i (.ref_clk(ref_clk), .rst(rst), .link(link),
    .core_done(core_done), .core_start(core_start), .core_kind(core_kind),
    .core_sector(core_sector), .protect_level(protect_level), .status_lock(status_lock),
    .write_latch(write_latch), .busy(busy), .power_mode(power_mode));
  fpph_asserts fpph_asserts_i (.ref_clk(ref_clk), .rst(rst), .cs_n(link.cs_n), .sck(link.sck),
    .mosi(link.mosi), .pause_n(link.pause_n), .miso_oe(link.miso_oe));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic prot(input logic [2:0] l, input logic [3:0] s);
    case (l)
      3'h0: return 1'b0;
      3'h1: return s == 4'hf;
      3'h2: return s >= 4'he;
      3'h3: return s >= 4'hc;
      3'h4: return s >= 4'h8;
      default: return 1'b1;
    endcase
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one command, then wait for idle and the flash decode gap
  task automatic send(input logic [7:0] op, input logic [7:0] b1, input logic [2:0] n,
    input logic al);
    @(posedge ref_clk);
    cmd_op <= op;
    cmd_arg <= {b1, 24'h0};
    cmd_nbytes <= n;
    cmd_auto_latch <= al;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1) @(posedge ref_clk);
    chk(8'(rx_valid), 8'h01);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic settle;
    while (busy !== 1'b0) @(posedge ref_clk);
  endtask

  // array model and hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    starts <= starts + int'(core_start);
    core_done <= (core_wait == 1);
    core_wait <= core_start ? 300 : (core_wait > 0 ? core_wait - 1 : 0);
    if (cyc == 40000)
    begin
      errors++;
      summarize();
    end
  end

  initial
  begin
    rst <= 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_arg = 32'h0;
    cmd_nbytes = 3'h1;
    cmd_auto_latch = 1'b0;
    pause_req = 1'b0;
    protect_drive_n = 1'b1;
    lfsr = 8'h31;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (120) @(posedge ref_clk);
    chk(8'(power_mode), 8'(fpph_pkg::FPPH_STANDBY));
    chk(8'(write_latch), 8'h00);
    send(8'h02, 8'h00, 3'h5, 1'b0);
    chk(8'(starts), 8'h00);
    $display("done: latch needed");
    for (int i = 1; i < 9; i++)
    begin
      lvl = 3'(i);
      send(8'h01, {3'h0, lvl, 2'h0}, 3'h2, 1'b1);
      exp_st++;
      chk(8'(power_mode), 8'(fpph_pkg::FPPH_ACTIVE));
      settle();
      chk(8'(protect_level), 8'(lvl));
      chk(8'(write_latch), 8'h00);
      chk(8'(core_kind), 8'(fpph_pkg::FPPH_K_STATUS));
      lfsr = next_rand(lfsr);
      sec = (i == 2) ? 4'hd : (i == 4) ? 4'h7 : lfsr[3:0];
      pr = prot(lvl, sec);
      send(8'hd8, {4'h0, sec}, 3'h4, 1'b1);
      exp_st += int'(!pr);
      chk(8'(starts), 8'(exp_st));
      if (!pr) chk(8'(core_sector), 8'(sec));
      if (!pr) chk(8'(core_kind), 8'(fpph_pkg::FPPH_K_BLOCK));
      settle();
      chk(8'(write_latch), 8'(pr));
      send(8'hc7, 8'h00, 3'h1, 1'b1);
      exp_st += int'(lvl == 3'h0);
      chk(8'(starts), 8'(exp_st));
      if (lvl == 3'h0) chk(8'(core_kind), 8'(fpph_pkg::FPPH_K_FULL));
      settle();
    end
    $display("done: protect levels");
    send(8'hb9, 8'h00, 3'h1, 1'b0);
    chk(8'(power_mode), 8'(fpph_pkg::FPPH_DEEP));
    send(8'h06, 8'h00, 3'h1, 1'b0);
    chk(8'(write_latch), 8'h00);
    send(8'hab, 8'h00, 3'h1, 1'b0);
    chk(8'(power_mode), 8'(fpph_pkg::FPPH_STANDBY));
    send(8'h06, 8'h00, 3'h1, 1'b0);
    chk(8'(write_latch), 8'h01);
    send(8'h04, 8'h00, 3'h1, 1'b0);
    chk(8'(write_latch), 8'h00);
    $display("done: deep power-down");
    send(8'h02, 8'h05, 3'h5, 1'b1);
    chk(8'(core_kind), 8'(fpph_pkg::FPPH_K_PROGRAM));
    // status read paused mid opcode, then in the data byte, while the program runs
    fork
      send(8'h05, 8'h00, 3'h2, 1'b0);
      begin
        repeat (60) @(posedge ref_clk);
        pause_req <= 1'b1;
        repeat (50) @(posedge ref_clk);
        pause_req <= 1'b0;
        repeat (17) @(posedge ref_clk);
        pause_req <= 1'b1;
        repeat (50) @(posedge ref_clk);
        pause_req <= 1'b0;
      end
    join
    chk(rx_byte & 8'hfd, 8'h01);
    chk(8'(busy), 8'h01);
    settle();
    $display("done: pause");
    send(8'h01, 8'h8c, 3'h2, 1'b1);
    settle();
    protect_drive_n <= 1'b0;
    send(8'h01, 8'h00, 3'h2, 1'b1);
    settle();
    chk({status_lock, 4'h0, protect_level}, 8'h83);
    protect_drive_n <= 1'b1;
    send(8'h01, 8'h00, 3'h2, 1'b1);
    settle();
    chk({status_lock, 4'h0, protect_level}, 8'h00);
    $display("done: protect pin");
    summarize();
  end
endmodule
`default_nettype wire
